// file: pwt_event_irq.sv
// Purpose: Event inputs, flags, sync-ready status and response decode of the PWM timer.
// Assumes: Event inputs are asynchronous; timer-side signals share core_clk.
// Notes:   Read data appear the cycle after the read strobe.
`timescale 1ns/1ps
module pwt_event_irq (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [pwt_pkg::ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic event_a,
   input wire logic event_b,
   input wire logic cycle_end,
   input wire logic waveform_out_a,
   input wire logic waveform_out_b,
   input wire pwt_pkg::pwt_cmd_t cmd,
   output logic command_ready,
   output logic enable_ready,
   output logic cmd_accept,
   output logic fault_a,
   output logic fault_b,
   output logic trigger_a,
   output logic trigger_b,
   output logic capture_a,
   output logic capture_b,
   output logic trigger_a_irq,
   output logic trigger_b_irq,
   output logic cycle_end_irq,
   output pwt_pkg::pwt_resp_t response_a,
   output pwt_pkg::pwt_resp_t response_b
);
   import pwt_pkg::*;

   // Elaboration check: the sync counter must be able to reach SYNC_CYCLES - 1
   if (SYNC_CYCLES < 1 || SYNC_CYCLES > (1 << CNT_W)) begin : g_bad_sync
      $error("SYNC_CYCLES does not fit the counter");
   end

   // ----------------------------------------
   // Response mode decode
   // ----------------------------------------
   // Used for both inputs; unknown codes decode to no action
   function automatic pwt_resp_t decode_mode(input logic [3:0] m);
      pwt_resp_t r;
      r = '0;
      case (m)
         4'h0: r = '0;
         4'h1: begin
            r.stop_own = 1'b1; // RULE_19
            r.jump_opposite_and_hold = 1'b1;
         end
         4'h2: begin
            r.stop_own = 1'b1; // RULE_19
            r.run_opposite_and_hold = 1'b1;
         end
         4'h3: begin
            r.stop_own = 1'b1; // RULE_19
            r.run_opposite_during_fault = 1'b1;
         end
         4'h4: begin
            r.stop_all = 1'b1; // RULE_20
            r.keep_period = 1'b1;
         end
         4'h5: begin
            r.stop_all = 1'b1; // RULE_20
            r.deadtime_during_fault = 1'b1;
         end
         4'h6: begin
            r.stop_all = 1'b1; // RULE_20
            r.jump_next_and_hold = 1'b1;
         end
         4'h7: begin
            r.stop_all = 1'b1; // RULE_20
            r.hold_for_software = 1'b1;
         end
         4'h8: r.edge_stop_next_cycle = 1'b1; // RULE_21
         4'h9: begin
            r.edge_stop_keep_period = 1'b1; // RULE_21
            r.keep_period = 1'b1;
         end
         4'hA: begin
            r.level_stop_keep_period = 1'b1; // RULE_21
            r.keep_period = 1'b1;
         end
         default: r = '0;
      endcase
      return r;
   endfunction

   pwt_state_t st;
   pwt_state_t next_st;
   logic halted;
   logic [1:0] raw;
   logic [1:0] rawact;
   logic [1:0] wave;
   logic [7:0] flg_set;
   logic cmd_any;

   // ----------------------------------------
   // Combinational helpers
   // ----------------------------------------
   // A halted timer ignores all events
   assign halted = cmd.debug_break & ~cmd.run_in_halt;
   assign raw = {event_b, event_a};
   assign wave = {waveform_out_b, waveform_out_a};
   assign cmd_any = cmd.sync_at_cycle_end | cmd.sync_now | cmd.restart // RULE_16
      | cmd.software_capture_a | cmd.software_capture_b
      | (cmd.compare_b_clear_high_wr & cmd.auto_update);

   // Async path skips the synchroniser, so it can glitch with the pin
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         rawact[i] = ~(raw[i] ^ st.evc[i][EVC_EDGE]); // RULE_05
      end
   end

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      logic [1:0] q;
      logic [1:0] cfg;
      q = '0;
      cfg = '0;
      next_st = st;
      flg_set = '0;
      for (int i = 0; i < 2; i++) begin
         cfg = st.evc[i][EVC_CFG_LO +: 2];
         // Two-flop synchroniser, then the sample history
         next_st.sy[i] = {st.sy[i][0], raw[i]};
         next_st.hist[i] = {st.hist[i][FILT_SAMPLES-2:0], st.sy[i][1]};
         // Newest sample is the fourth of the window, so the filter adds four cycles, not five
         if (next_st.hist[i] == '0 || next_st.hist[i] == '1) begin
            next_st.filt[i] = st.sy[i][1]; // RULE_01 RULE_02
         end
         // Reserved configuration behaves as plain synchronised input
         q[i] = (cfg == CFG_FILTER) ? st.filt[i] : st.sy[i][1]; // RULE_04
         next_st.lvl[i] = ~(q[i] ^ st.evc[i][EVC_EDGE]); // RULE_05
         next_st.trg[i] = next_st.lvl[i] & ~st.lvl[i] & st.evc[i][EVC_TRIG_EN] & ~halted; // RULE_07
         next_st.cap[i] = next_st.trg[i] & st.evc[i][EVC_ACTION]; // RULE_06
         next_st.wv[i] = wave[i];
      end
      // Trigger flag follows trigger or capture of its own input
      flg_set[BIT_TRIG_A] = st.trg[0] | st.cap[0]; // RULE_09
      flg_set[BIT_TRIG_B] = st.trg[1] | st.cap[1]; // RULE_09
      flg_set[BIT_CYC_END] = cycle_end; // RULE_10
      next_st.flg = st.flg | flg_set;
      // Any level change of a waveform output marks activity
      next_st.act = st.act | (wave ^ st.wv); // RULE_12 RULE_13

      // Command synchronisation; strobes while busy are dropped
      next_st.cmd_go = 1'b0;
      if (st.cmd_rdy) begin
         if (cmd_any) begin
            next_st.cmd_rdy = 1'b0; // RULE_16 RULE_22
            next_st.cmd_cnt = '0;
            next_st.cmd_go = 1'b1;
         end
      end else if (st.cmd_cnt == CNT_W'(SYNC_CYCLES - 1)) begin
         next_st.cmd_rdy = 1'b1; // RULE_15
      end else begin
         next_st.cmd_cnt = st.cmd_cnt + 1'b1;
      end

      // Enable synchronisation; break without run-in-halt holds it not ready
      if (cmd.enable_wr || halted || (cmd.disable_at_cycle_end && st.en_rdy)) begin
         next_st.en_rdy = 1'b0; // RULE_18
         next_st.en_cnt = '0;
      end else if (!st.en_rdy) begin
         if (st.en_cnt == CNT_W'(SYNC_CYCLES - 1)) begin
            next_st.en_rdy = 1'b1; // RULE_17
         end else begin
            next_st.en_cnt = st.en_cnt + 1'b1;
         end
      end

      // Register writes; hardware sets win over write-one clears
      if (wr) begin
         case (addr)
            OFS_EVC_A: next_st.evc[0] = wdata & EVC_MASK;
            OFS_EVC_B: next_st.evc[1] = wdata & EVC_MASK; // RULE_07
            OFS_IEN: next_st.ien = wdata & IRQ_MASK; // RULE_08
            OFS_FLG: next_st.flg = (st.flg & ~(wdata & IRQ_MASK)) | flg_set; // RULE_11
            OFS_STAT: begin
               next_st.act[1] = (st.act[1] & ~wdata[BIT_ACT_B]) | (wave[1] ^ st.wv[1]); // RULE_14
               next_st.act[0] = (st.act[0] & ~wdata[BIT_ACT_A]) | (wave[0] ^ st.wv[0]); // RULE_14
            end
            OFS_RESP_A: next_st.resp[0] = wdata & RESP_MASK;
            OFS_RESP_B: next_st.resp[1] = wdata & RESP_MASK;
            default: ;
         endcase
      end

      // Read data are registered; unmapped addresses read zero
      next_st.rdata = RST_VAL;
      if (rd) begin
         case (addr)
            OFS_EVC_A: next_st.rdata = st.evc[0];
            OFS_EVC_B: next_st.rdata = st.evc[1];
            OFS_IEN: next_st.rdata = st.ien;
            OFS_FLG: next_st.rdata = st.flg;
            OFS_STAT: begin
               next_st.rdata[BIT_ACT_B] = st.act[1];
               next_st.rdata[BIT_ACT_A] = st.act[0];
               next_st.rdata[BIT_CMD_RDY] = st.cmd_rdy; // RULE_15
               next_st.rdata[BIT_EN_RDY] = st.en_rdy; // RULE_17
            end
            OFS_RESP_A: next_st.rdata = st.resp[0];
            OFS_RESP_B: next_st.rdata = st.resp[1];
            default: next_st.rdata = RST_VAL;
         endcase
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0; // RULE_24
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign rdata = st.rdata;
   assign command_ready = st.cmd_rdy;
   assign enable_ready = st.en_rdy;
   assign cmd_accept = st.cmd_go;
   assign trigger_a = st.trg[0];
   assign trigger_b = st.trg[1];
   assign capture_a = st.cap[0];
   assign capture_b = st.cap[1];
   // Fault is a level; async mode bypasses the synchroniser
   assign fault_a = st.evc[0][EVC_TRIG_EN] & ~halted // RULE_03
      & ((st.evc[0][EVC_CFG_LO +: 2] == CFG_ASYNC) ? rawact[0] : st.lvl[0]);
   assign fault_b = st.evc[1][EVC_TRIG_EN] & ~halted // RULE_03
      & ((st.evc[1][EVC_CFG_LO +: 2] == CFG_ASYNC) ? rawact[1] : st.lvl[1]);
   assign trigger_a_irq = st.flg[BIT_TRIG_A] & st.ien[BIT_TRIG_A]; // RULE_23
   assign trigger_b_irq = st.flg[BIT_TRIG_B] & st.ien[BIT_TRIG_B]; // RULE_23
   assign cycle_end_irq = st.flg[BIT_CYC_END] & st.ien[BIT_CYC_END]; // RULE_23
   assign response_a = decode_mode(st.resp[0][3:0]);
   assign response_b = decode_mode(st.resp[1][3:0]);
endmodule

// file: pwt_pkg.sv
// Purpose: Constants and types for the timer event, flag and status block.
// Assumes: One clock, byte-wide register port, printed offsets used as addresses.
// Notes:   All registers reset to zero.
// Function
// RULE_01: Noise filter changes its output only after four equal samples in a row.
// RULE_02: Filtered path lags the unfiltered input by four clock cycles.
// RULE_03: Asynchronous qualification drives the fault output straight from the event.
// RULE_04: Configuration zero means neither filter nor async; value three is reserved.
// RULE_05: Polarity zero selects falling edge or low level, one rising or high.
// RULE_06: Action zero raises fault only; one raises fault plus capture.
// RULE_07: Trigger enable routes the event as trigger; each input has its own controls.
// RULE_08: Interrupt enables sit at bit 3 for B, bit 2 for A, bit 0 cycle end.
// RULE_09: Trigger or capture on an input sets that input's trigger flag.
// RULE_10: Cycle-end flag at bit 0 is set when each timer cycle ends.
// RULE_11: Flags clear only by writing one; writing zero leaves them alone.
// RULE_12: Waveform B activity bit sets on any level change of waveform B.
// RULE_13: Waveform A activity bit sets on any level change of waveform A.
// RULE_14: Software clears an activity bit by writing one before new detection.
// RULE_15: Command-ready reads high once the last command has synchronised.
// RULE_16: Command strobes, or compare B high write with auto update, clear command-ready.
// RULE_17: Enable-ready reads high once the enable value has synchronised.
// RULE_18: Enable write, disable-at-cycle-end, or break without run-in-halt clear enable-ready.
// RULE_19: Response modes 1 to 3 stop one output and work the opposite cycle.
// RULE_20: Response modes 4 to 7 stop all outputs with their listed follow-up.
// RULE_21: Response modes 8 to A stop on edge or level as listed.
// RULE_22: Command strobes during an ongoing synchronisation are ignored.
// RULE_23: Each interrupt request is high while its flag and enable are both set.
// RULE_24: Every register resets to zero.
package pwt_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam int ADDR_W = 5;
   localparam logic [4:0] OFS_EVC_A = 5'h08;
   localparam logic [4:0] OFS_EVC_B = 5'h09;
   localparam logic [4:0] OFS_IEN = 5'h0C;
   localparam logic [4:0] OFS_FLG = 5'h0D;
   localparam logic [4:0] OFS_STAT = 5'h0E;
   localparam logic [4:0] OFS_RESP_A = 5'h10;
   localparam logic [4:0] OFS_RESP_B = 5'h11;
   localparam logic [7:0] RST_VAL = 8'h00;
   // ----------------------------------------
   // Field positions and masks
   // ----------------------------------------
   localparam int EVC_CFG_LO = 6;
   localparam int EVC_EDGE = 4;
   localparam int EVC_ACTION = 2;
   localparam int EVC_TRIG_EN = 0;
   localparam logic [7:0] EVC_MASK = 8'hD5;
   localparam int BIT_TRIG_B = 3;
   localparam int BIT_TRIG_A = 2;
   localparam int BIT_CYC_END = 0;
   localparam logic [7:0] IRQ_MASK = 8'h0D;
   localparam int BIT_ACT_B = 7;
   localparam int BIT_ACT_A = 6;
   localparam int BIT_CMD_RDY = 1;
   localparam int BIT_EN_RDY = 0;
   localparam logic [7:0] RESP_MASK = 8'h0F;
   localparam logic [1:0] CFG_NEITHER = 2'h0;
   localparam logic [1:0] CFG_FILTER = 2'h1;
   localparam logic [1:0] CFG_ASYNC = 2'h2;
   // ----------------------------------------
   // Timing counts
   // ----------------------------------------
   localparam int FILT_SAMPLES = 4;
   localparam int SYNC_CYCLES = 3;
   localparam int CNT_W = 2;

   // Strobes from the control registers outside this block
   typedef struct packed {
      logic sync_at_cycle_end;
      logic sync_now;
      logic restart;
      logic software_capture_a;
      logic software_capture_b;
      logic compare_b_clear_high_wr;
      logic auto_update;
      logic enable_wr;
      logic disable_at_cycle_end;
      logic debug_break;
      logic run_in_halt;
   } pwt_cmd_t;

   // Decoded input response mode
   typedef struct packed {
      logic stop_own;
      logic stop_all;
      logic jump_opposite_and_hold;
      logic run_opposite_and_hold;
      logic run_opposite_during_fault;
      logic keep_period;
      logic deadtime_during_fault;
      logic jump_next_and_hold;
      logic hold_for_software;
      logic edge_stop_next_cycle;
      logic edge_stop_keep_period;
      logic level_stop_keep_period;
   } pwt_resp_t;

   // Complete block state
   typedef struct packed {
      logic [1:0][7:0] evc;
      logic [1:0][7:0] resp;
      logic [7:0] ien;
      logic [7:0] flg;
      logic [1:0] act;
      logic cmd_rdy;
      logic en_rdy;
      logic [CNT_W-1:0] cmd_cnt;
      logic [CNT_W-1:0] en_cnt;
      logic [1:0][1:0] sy;
      logic [1:0][FILT_SAMPLES-1:0] hist;
      logic [1:0] filt;
      logic [1:0] lvl;
      logic [1:0] trg;
      logic [1:0] cap;
      logic [1:0] wv;
      logic cmd_go;
      logic [7:0] rdata;
   } pwt_state_t;
endpackage

// file: pwt_evsys_model.sv
// Purpose: Event system stand-in that launches the two event levels.
// Assumes: The bench requests levels; the model only times them.
// Notes:   Adds one edge of latency, which the bench waits include.
`timescale 1ns/1ps
module pwt_evsys_model (
   input wire logic core_clk,
   input wire logic lvl_a,
   input wire logic lvl_b,
   output logic event_a,
   output logic event_b
);
   // Launch just after an edge, like a real routed event
   always_ff @(posedge core_clk) begin
      event_a <= lvl_a;
      event_b <= lvl_b;
   end
endmodule

// file: pwt_event_irq_assertions.sv
// Purpose: Port-level timing checks of the event block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Flag state is internal, so irq rises are tied to their causes.
`timescale 1ns/1ps
module pwt_event_irq_chk (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic wr,
   input wire logic cycle_end,
   input wire pwt_pkg::pwt_cmd_t cmd,
   input wire logic command_ready,
   input wire logic enable_ready,
   input wire logic cmd_accept,
   input wire logic trigger_a,
   input wire logic capture_a,
   input wire logic trigger_a_irq,
   input wire logic cycle_end_irq
);
   import pwt_pkg::*;
   logic strb;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // Any strobe that starts a command sync
   assign strb = cmd.sync_at_cycle_end | cmd.sync_now | cmd.restart | cmd.software_capture_a |
      cmd.software_capture_b | (cmd.compare_b_clear_high_wr & cmd.auto_update);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   cmd_take_a: assert property (command_ready && strb |=> cmd_accept && !command_ready)
      else $error("command strobe not taken");
   cmd_ignore_a: assert property (!command_ready && strb |=> !cmd_accept)
      else $error("strobe taken during sync");
   cmd_back_a: assert property ($fell(command_ready) |-> !command_ready[*3] ##[1:3] command_ready)
      else $error("command ready timing wrong");
   en_write_a: assert property (cmd.enable_wr && enable_ready |=> !enable_ready)
      else $error("enable write kept ready");
   en_break_a: assert property (cmd.debug_break && !cmd.run_in_halt |=> !enable_ready)
      else $error("break kept enable ready");
   trig_pulse_a: assert property (trigger_a |=> !trigger_a)
      else $error("trigger longer than one cycle");
   cap_with_trig_a: assert property (capture_a |-> trigger_a)
      else $error("capture without trigger");
   trig_irq_a: assert property ($rose(trigger_a_irq) |-> $past(trigger_a) || $past(wr))
      else $error("trigger irq without cause");
   cyc_irq_a: assert property ($rose(cycle_end_irq) |-> $past(cycle_end) || $past(wr))
      else $error("cycle irq without cause");
endmodule
bind pwt_event_irq pwt_event_irq_chk i_pwt_event_irq_chk (.core_clk(core_clk), .rstn(rstn), .wr(wr),
   .cycle_end(cycle_end), .cmd(cmd), .command_ready(command_ready), .enable_ready(enable_ready),
   .cmd_accept(cmd_accept), .trigger_a(trigger_a), .capture_a(capture_a),
   .trigger_a_irq(trigger_a_irq), .cycle_end_irq(cycle_end_irq));

// file: pwt_event_irq_tb.sv
// Purpose: Register, event, flag and sync-ready tests of the event block.
// Assumes: Event levels reach the pins through the event system model.
// Notes:   Trigger waits count edges from the level request.
`timescale 1ns/1ps
module pwt_event_irq_tb;
   import pwt_pkg::*;
   logic core_clk, rstn, wr, rd, cycle_end, wva, wvb, lvl_a, lvl_b, event_a, event_b;
   logic [4:0] addr;
   logic [7:0] wdata, rdata;
   logic command_ready, enable_ready, cmd_accept, fault_a, fault_b, trigger_a, trigger_b;
   logic capture_a, capture_b, trigger_a_irq, trigger_b_irq, cycle_end_irq, b;
   pwt_cmd_t cmd;
   pwt_resp_t response_a, response_b;
   int num_errors = 0;
   int compares = 0;
   int ntb = 0;
   logic [4:0] regs[6] = '{OFS_EVC_A, OFS_EVC_B, OFS_IEN, OFS_FLG, OFS_RESP_A, OFS_RESP_B};
   logic [10:0] cmdv[6] = '{11'h400, 11'h200, 11'h100, 11'h080, 11'h040, 11'h030};
   logic [10:0] env[4] = '{11'h008, 11'h004, 11'h002, 11'h003};

   pwt_evsys_model i_pwt_evsys_model (.core_clk(core_clk), .lvl_a(lvl_a), .lvl_b(lvl_b),
      .event_a(event_a), .event_b(event_b));
   pwt_event_irq i_pwt_event_irq (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .event_a(event_a), .event_b(event_b), .cycle_end(cycle_end),
      .waveform_out_a(wva), .waveform_out_b(wvb), .cmd(cmd), .command_ready(command_ready),
      .enable_ready(enable_ready), .cmd_accept(cmd_accept), .fault_a(fault_a), .fault_b(fault_b),
      .trigger_a(trigger_a), .trigger_b(trigger_b), .capture_a(capture_a), .capture_b(capture_b),
      .trigger_a_irq(trigger_a_irq), .trigger_b_irq(trigger_b_irq), .cycle_end_irq(cycle_end_irq),
      .response_a(response_a), .response_b(response_b));

   // ----------------------------------------
   // Clock, watchdog, trigger B counter
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // Whole run is well under 1500 cycles
   initial begin
      #300000;
      num_errors++;
      tally_and_finish();
   end
   always @(posedge core_clk) begin
      if (trigger_b === 1'b1) ntb++;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic ck1(input logic g, input logic e);
      chk({7'h0, g}, {7'h0, e});
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   task automatic wreg(input logic [4:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rchk(input logic [4:0] a, input logic [7:0] e);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask
   // Strobe held for exactly one sampled cycle
   task automatic pulse(input logic [10:0] v);
      @(posedge core_clk);
      cmd <= pwt_cmd_t'(v);
      @(posedge core_clk);
      cmd <= '0;
      #1;
   endtask
   // Bounded wait so a missing trigger cannot hang the run
   task automatic twait(input bit sb, input int exp);
      int k;
      k = 0;
      do begin
         tick(1);
         k++;
      end while (((sb ? trigger_b : trigger_a) !== 1'b1) && k < 20);
      chk(8'(k), 8'(exp));
   endtask
   task automatic tally_and_finish();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rstn, wr, rd, cycle_end, wva, wvb, lvl_a, lvl_b} = '0;
      addr = '0;
      wdata = '0;
      cmd = '0;
      repeat (16) @(posedge core_clk);
      rstn <= 1'b1;
      foreach (regs[i]) rchk(regs[i], 8'h00);
      rchk(OFS_STAT, 8'h03);
      // Reserved bits, unmapped place, read-only ready bits
      wreg(OFS_EVC_A, 8'hFF);
      rchk(OFS_EVC_A, 8'hD5);
      wreg(OFS_IEN, 8'hFF);
      rchk(OFS_IEN, 8'h0D);
      wreg(5'h1F, 8'hFF);
      rchk(5'h1F, 8'h00);
      wreg(OFS_STAT, 8'h03);
      rchk(OFS_STAT, 8'h03);
      // Rising edge on A, fault only, flag and irq
      wreg(OFS_EVC_A, 8'h11);
      wreg(OFS_IEN, 8'h04);
      lvl_a <= 1'b1;
      twait(0, 4);
      ck1(fault_a, 1'b1);
      ck1(capture_a, 1'b0);
      tick(2);
      ck1(trigger_a_irq, 1'b1);
      rchk(OFS_FLG, 8'h04);
      wreg(OFS_FLG, 8'h00);
      rchk(OFS_FLG, 8'h04);
      wreg(OFS_FLG, 8'h04);
      rchk(OFS_FLG, 8'h00);
      ck1(trigger_a_irq, 1'b0);
      // Falling edge with capture on A
      wreg(OFS_EVC_A, 8'h05);
      lvl_a <= 1'b0;
      twait(0, 4);
      ck1(capture_a, 1'b1);
      // Async qualification bypasses the synchronisers
      wreg(OFS_EVC_A, 8'h81);
      lvl_a <= 1'b1;
      tick(1);
      ck1(fault_a, 1'b0);
      lvl_a <= 1'b0;
      tick(1);
      ck1(fault_a, 1'b1);
      // Filtered B: a three-sample glitch must not pass
      wreg(OFS_EVC_B, 8'h55);
      lvl_b <= 1'b1;
      repeat (3) @(posedge core_clk);
      lvl_b <= 1'b0;
      tick(12);
      chk(8'(ntb), 8'h00);
      lvl_b <= 1'b1;
      twait(1, 8);
      ck1(capture_b, 1'b1);
      ck1(fault_b, 1'b1);
      wreg(OFS_IEN, 8'h08);
      ck1(trigger_b_irq, 1'b1);
      // Cycle end flag
      wreg(OFS_IEN, 8'h01);
      wreg(OFS_FLG, 8'h0D);
      @(posedge core_clk);
      cycle_end <= 1'b1;
      @(posedge core_clk);
      cycle_end <= 1'b0;
      tick(1);
      ck1(cycle_end_irq, 1'b1);
      rchk(OFS_FLG, 8'h01);
      // Waveform activity bits, cleared by writing one
      @(posedge core_clk);
      wva <= 1'b1;
      tick(3);
      rchk(OFS_STAT, 8'h43);
      wreg(OFS_STAT, 8'h40);
      rchk(OFS_STAT, 8'h03);
      @(posedge core_clk);
      wva <= 1'b0;
      wvb <= 1'b1;
      tick(3);
      rchk(OFS_STAT, 8'hC3);
      // Each command strobe, then a strobe while busy
      foreach (cmdv[i]) begin
         pulse(cmdv[i]);
         chk({6'h0, cmd_accept, command_ready}, 8'h02);
         pulse(11'h200);
         ck1(cmd_accept, 1'b0);
         tick(6);
         ck1(command_ready, 1'b1);
      end
      pulse(11'h020);
      ck1(cmd_accept, 1'b0);
      // Enable-ready clearing causes; break with run-in-halt keeps it
      foreach (env[i]) begin
         pulse(env[i]);
         ck1(enable_ready, i == 3);
         tick(6);
         ck1(enable_ready, 1'b1);
      end
      // Every response mode code
      for (int m = 0; m <= 10; m++) begin
         wreg(OFS_RESP_A, 8'(m));
         case (m)
            1: b = response_a.jump_opposite_and_hold;
            2: b = response_a.run_opposite_and_hold;
            3: b = response_a.run_opposite_during_fault;
            4: b = response_a.keep_period;
            5: b = response_a.deadtime_during_fault;
            6: b = response_a.jump_next_and_hold;
            7: b = response_a.hold_for_software;
            8: b = response_a.edge_stop_next_cycle;
            9: b = response_a.edge_stop_keep_period;
            10: b = response_a.level_stop_keep_period;
            default: b = (response_a === '0);
         endcase
         chk({5'h0, response_a.stop_own, response_a.stop_all, b},
            {5'h0, m >= 1 && m <= 3, m >= 4 && m <= 7, 1'b1});
      end
      wreg(OFS_RESP_B, 8'h07);
      ck1(response_b.hold_for_software, 1'b1);
      tally_and_finish();
   end
endmodule
